// >>> include/mfx_pkg.sv
// Constants and types shared by the memory field extension design
package mfx_pkg;

  // Bank number width used in this mode, and physical register widths
  localparam int unsigned FIELD_W      = 3;
  localparam int unsigned FIELD_PHYS_W = 5;
  localparam int unsigned SAVE_W       = 6;
  localparam int unsigned SAVE_PHYS_W  = 10;
  localparam int unsigned WORD_W       = 12;

  // Reset value of every field register
  localparam logic [FIELD_W-1:0] FIELD_RST = 3'h0;
  localparam logic [SAVE_W-1:0]  SAVE_RST  = 6'h00;

  // Instruction word fields, bit 11 of the word is the most significant
  localparam int unsigned OPC_MSB  = 11;
  localparam int unsigned OPC_LSB  = 6;
  localparam int unsigned N_MSB    = 5;
  localparam int unsigned N_LSB    = 3;
  localparam int unsigned SUB_MSB  = 2;
  localparam int unsigned PAGE_BIT = 7;
  localparam int unsigned OFS_MSB  = 6;
  localparam int unsigned PG_MSB   = 11;
  localparam int unsigned PG_LSB   = 7;

  // Group code 62 octal and sub-codes of the bank-change operations
  localparam logic [5:0] OPC_BANK      = 6'h32;
  localparam logic [2:0] SUB_SET_DATA  = 3'h1;
  localparam logic [2:0] SUB_SET_FETCH = 3'h2;

  // Whole-word codes of the read and restore operations (6214..6244 octal)
  localparam logic [11:0] OP_READ_DATA  = 12'hc8c;
  localparam logic [11:0] OP_READ_FETCH = 12'hc94;
  localparam logic [11:0] OP_READ_SAVED = 12'hc9c;
  localparam logic [11:0] OP_RESTORE    = 12'ha4 | 12'hc00;

  // Save field layout: saved instruction bank high, saved data bank low
  localparam int unsigned SF_IF_MSB = 5;
  localparam int unsigned SF_IF_LSB = 3;
  localparam int unsigned SF_DF_MSB = 2;

  // Working register bit positions (bits 6-8 and 9-11 counted from the top)
  localparam int unsigned WR_HI_MSB = 5;
  localparam int unsigned WR_HI_LSB = 3;
  localparam int unsigned WR_LO_MSB = 2;

  // Interrupt entry: bank 0, pc stored at 0000, resume at 0001
  localparam logic [FIELD_W-1:0] INTR_BANK      = 3'h0;
  localparam logic [11:0]        INTR_SAVE_ADDR = 12'h000;
  localparam logic [11:0]        INTR_NEXT_ADDR = 12'h001;

  // Execution time of one transfer instruction
  localparam int unsigned CLK_PERIOD_PS = 20000;
  localparam int unsigned IOT_TIME_PS   = 4300000;
  localparam int unsigned IOT_CYCLES    = IOT_TIME_PS / CLK_PERIOD_PS;
  localparam int unsigned CNT_W         = 8;

  // Kind of memory cycle the sequencer is running
  typedef enum logic [1:0]
  {
    MFX_CYC_DIRECT,
    MFX_CYC_POINTER,
    MFX_CYC_OPERAND,
    MFX_CYC_BREAK
  } mfx_cyc_t;

  // Transfer instruction sequencing
  typedef enum logic
  {
    MFX_IDLE,
    MFX_BUSY
  } mfx_state_t;

endpackage

// >>> rtl/mfx_bank_sel.sv
// Memory bank and direct address selection for each memory cycle
`timescale 1ns/1ps
`default_nettype none

module mfx_bank_sel
(
  // Cycle description
  input  wire mfx_pkg::mfx_cyc_t cyc_kind_i,
  input  wire logic              intr_take_i,
  input  wire logic [11:0]       instr_i,
  input  wire logic [11:0]       pc_i,
  // Field registers
  input  wire logic [2:0]        instr_bank_i,
  input  wire logic [2:0]        data_bank_i,
  input  wire logic [2:0]        break_bank_i,
  // Selection
  output logic      [2:0]        mem_bank_o,
  output logic      [11:0]       direct_addr_o
);

  // Interrupt entry overrides every field register
  always_comb
  begin
    if (intr_take_i)
      mem_bank_o = mfx_pkg::INTR_BANK;
    else
    begin
      case (cyc_kind_i)
        mfx_pkg::MFX_CYC_DIRECT:  mem_bank_o = instr_bank_i;
        mfx_pkg::MFX_CYC_POINTER: mem_bank_o = instr_bank_i;
        mfx_pkg::MFX_CYC_OPERAND: mem_bank_o = data_bank_i;
        mfx_pkg::MFX_CYC_BREAK:   mem_bank_o = break_bank_i;
        default:                  mem_bank_o = instr_bank_i;
      endcase
    end
  end

  // Page zero or current page, offset from the low seven bits
  always_comb
  begin
    direct_addr_o = {5'h00, instr_i[mfx_pkg::OFS_MSB:0]};
    if (instr_i[mfx_pkg::PAGE_BIT])
      direct_addr_o = {pc_i[mfx_pkg::PG_MSB:mfx_pkg::PG_LSB], instr_i[mfx_pkg::OFS_MSB:0]};
  end

endmodule

`default_nettype wire

// >>> rtl/mfx_ctrl.sv
// Memory field extension control: field registers, transfer ops and bank selection
`timescale 1ns/1ps
`default_nettype none

module mfx_ctrl
#(
  parameter int unsigned IOT_CYCLES = mfx_pkg::IOT_CYCLES
)
(
  // Clock and reset
  input  wire logic              mclk_i,
  input  wire logic              reset_i,
  // Transfer instruction from the sequencer
  input  wire logic              iot_strobe_i,
  input  wire logic [11:0]       instr_i,
  input  wire logic [11:0]       work_reg_i,
  output logic                   iot_busy_o,
  output logic                   iot_done_o,
  output logic      [11:0]       work_reg_o,
  output logic                   work_reg_load_o,
  // Sequencer events
  input  wire logic              jump_i,
  input  wire logic              intr_take_i,
  input  wire logic              console_load_i,
  input  wire logic [2:0]        console_bank_i,
  input  wire logic              break_load_i,
  input  wire logic [2:0]        break_bank_i,
  // Memory cycle
  input  wire mfx_pkg::mfx_cyc_t cyc_kind_i,
  input  wire logic [11:0]       pc_i,
  output logic      [2:0]        mem_bank_o,
  output logic      [11:0]       direct_addr_o,
  output logic      [11:0]       intr_save_addr_o,
  output logic      [11:0]       intr_next_addr_o,
  // Register view
  output logic      [4:0]        instruction_bank_o,
  output logic      [4:0]        data_bank_select_o,
  output logic      [4:0]        fetch_bank_staging_o,
  output logic      [9:0]        interrupt_bank_save_o,
  output logic      [2:0]        transfer_bank_select_o
);

  // Field registers
  logic [2:0]  instruction_bank;
  logic [2:0]  data_bank_select;
  logic [2:0]  fetch_bank_staging;
  logic [5:0]  interrupt_bank_save;
  logic [2:0]  transfer_bank_select;
  logic [2:0]  next_instruction_bank;
  logic [2:0]  next_data_bank_select;
  logic [2:0]  next_fetch_bank_staging;
  logic [5:0]  next_interrupt_bank_save;
  logic [2:0]  next_transfer_bank_select;

  // Transfer sequencing
  mfx_pkg::mfx_state_t state;
  mfx_pkg::mfx_state_t next_state;
  logic [7:0]  cnt;
  logic [7:0]  next_cnt;
  logic [11:0] next_work_reg;
  logic        wr_pending;
  logic        next_wr_pending;
  logic        take;
  logic [2:0]  op_n;

  // True when the word is one of this block's transfer instructions
  function automatic logic is_mfx_op(input logic [11:0] w);
    logic grp;
    grp = (w[mfx_pkg::OPC_MSB:mfx_pkg::OPC_LSB] == mfx_pkg::OPC_BANK);
    is_mfx_op = (grp && (w[mfx_pkg::SUB_MSB:0] == mfx_pkg::SUB_SET_DATA))
             || (grp && (w[mfx_pkg::SUB_MSB:0] == mfx_pkg::SUB_SET_FETCH))
             || (w == mfx_pkg::OP_READ_DATA) || (w == mfx_pkg::OP_READ_FETCH)
             || (w == mfx_pkg::OP_READ_SAVED) || (w == mfx_pkg::OP_RESTORE);
  endfunction

  // Matches a bank-change op with the given sub-code
  function automatic logic is_set(input logic [11:0] w, input logic [2:0] sub);
    is_set = (w[mfx_pkg::OPC_MSB:mfx_pkg::OPC_LSB] == mfx_pkg::OPC_BANK)
          && (w[mfx_pkg::SUB_MSB:0] == sub);
  endfunction

  // A new instruction is refused while one is still executing
  assign take = iot_strobe_i && (state == mfx_pkg::MFX_IDLE) && is_mfx_op(instr_i);
  assign op_n = instr_i[mfx_pkg::N_MSB:mfx_pkg::N_LSB];

  // Next field register values; interrupt entry has highest priority
  always_comb
  begin
    next_instruction_bank     = instruction_bank;
    next_data_bank_select     = data_bank_select;
    next_fetch_bank_staging   = fetch_bank_staging;
    next_interrupt_bank_save  = interrupt_bank_save;
    next_transfer_bank_select = transfer_bank_select;
    if (break_load_i)
      next_transfer_bank_select = break_bank_i;
    if (take && is_set(instr_i, mfx_pkg::SUB_SET_DATA))
      next_data_bank_select = op_n;
    if (take && is_set(instr_i, mfx_pkg::SUB_SET_FETCH))
      next_fetch_bank_staging = op_n;
    if (take && (instr_i == mfx_pkg::OP_RESTORE))
    begin
      next_fetch_bank_staging = interrupt_bank_save[mfx_pkg::SF_IF_MSB:mfx_pkg::SF_IF_LSB];
      next_data_bank_select   = interrupt_bank_save[mfx_pkg::SF_DF_MSB:0];
    end
    // Staging reaches the fetch bank only at a jump or call
    if (jump_i)
      next_instruction_bank = fetch_bank_staging;
    // Console load skips staging, as interrupt entry below also does; staging follows it
    if (console_load_i)
    begin
      next_instruction_bank   = console_bank_i;
      next_fetch_bank_staging = console_bank_i;
    end
    if (intr_take_i)
    begin
      next_interrupt_bank_save = {instruction_bank, data_bank_select};
      next_instruction_bank    = mfx_pkg::INTR_BANK;
      next_data_bank_select    = mfx_pkg::INTR_BANK;
      next_fetch_bank_staging  = mfx_pkg::INTR_BANK;
    end
  end

  // Field registers clear to bank 0 at reset
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      instruction_bank     <= mfx_pkg::FIELD_RST;
      data_bank_select     <= mfx_pkg::FIELD_RST;
      fetch_bank_staging   <= mfx_pkg::FIELD_RST;
      interrupt_bank_save  <= mfx_pkg::SAVE_RST;
      transfer_bank_select <= mfx_pkg::FIELD_RST;
    end
    else
    begin
      instruction_bank     <= next_instruction_bank;
      data_bank_select     <= next_data_bank_select;
      fetch_bank_staging   <= next_fetch_bank_staging;
      interrupt_bank_save  <= next_interrupt_bank_save;
      transfer_bank_select <= next_transfer_bank_select;
    end
  end

  // Execution timer and working register result
  always_comb
  begin
    next_state      = state;
    next_cnt        = cnt;
    next_work_reg   = work_reg_o;
    next_wr_pending = wr_pending;
    case (state)
      mfx_pkg::MFX_IDLE:
      begin
        if (take)
        begin
          next_state      = mfx_pkg::MFX_BUSY;
          next_cnt        = 8'(IOT_CYCLES - 1);
          next_wr_pending = 1'b0;
          next_work_reg   = work_reg_i;
          if (instr_i == mfx_pkg::OP_READ_DATA)
          begin
            next_work_reg[mfx_pkg::WR_HI_MSB:mfx_pkg::WR_HI_LSB] = data_bank_select;
            next_wr_pending = 1'b1;
          end
          if (instr_i == mfx_pkg::OP_READ_FETCH)
          begin
            next_work_reg[mfx_pkg::WR_HI_MSB:mfx_pkg::WR_HI_LSB] = instruction_bank;
            next_wr_pending = 1'b1;
          end
          if (instr_i == mfx_pkg::OP_READ_SAVED)
          begin
            next_work_reg[mfx_pkg::WR_HI_MSB:mfx_pkg::WR_HI_LSB] =
              interrupt_bank_save[mfx_pkg::SF_IF_MSB:mfx_pkg::SF_IF_LSB];
            next_work_reg[mfx_pkg::WR_LO_MSB:0] = interrupt_bank_save[mfx_pkg::SF_DF_MSB:0];
            next_wr_pending = 1'b1;
          end
        end
      end
      mfx_pkg::MFX_BUSY:
      begin
        if (cnt == 8'h00)
          next_state = mfx_pkg::MFX_IDLE;
        else
          next_cnt = cnt - 8'h01;
      end
      default:
        next_state = mfx_pkg::MFX_IDLE;
    endcase
  end

  // Timer registers
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      state      <= mfx_pkg::MFX_IDLE;
      cnt        <= 8'h00;
      work_reg_o <= 12'h000;
      wr_pending <= 1'b0;
    end
    else
    begin
      state      <= next_state;
      cnt        <= next_cnt;
      work_reg_o <= next_work_reg;
      wr_pending <= next_wr_pending;
    end
  end

  // Handshake outputs; result is handed back only for read ops
  assign iot_busy_o      = (state == mfx_pkg::MFX_BUSY);
  assign iot_done_o      = iot_busy_o && (cnt == 8'h00);
  assign work_reg_load_o = iot_done_o && wr_pending;

  // Unused low bits, and the top four bits of the save field, belong to the other mode and read as zero
  assign instruction_bank_o     = {instruction_bank, 2'h0};
  assign data_bank_select_o     = {data_bank_select, 2'h0};
  assign fetch_bank_staging_o   = {fetch_bank_staging, 2'h0};
  assign interrupt_bank_save_o  = {4'h0, interrupt_bank_save};
  assign transfer_bank_select_o = transfer_bank_select;
  assign intr_save_addr_o       = mfx_pkg::INTR_SAVE_ADDR;
  assign intr_next_addr_o       = mfx_pkg::INTR_NEXT_ADDR;

  // Jump target fetch uses the bank already updated from staging, so the
  // sequencer must issue the target fetch after the jump cycle
  mfx_bank_sel u_bank_sel
  (
    .cyc_kind_i    (cyc_kind_i),
    .intr_take_i   (intr_take_i),
    .instr_i       (instr_i),
    .pc_i          (pc_i),
    .instr_bank_i  (instruction_bank),
    .data_bank_i   (data_bank_select),
    .break_bank_i  (transfer_bank_select),
    .mem_bank_o    (mem_bank_o),
    .direct_addr_o (direct_addr_o)
  );

  // Checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  chk_jump_loads_fetch: assert property (
    jump_i && !intr_take_i && !console_load_i |=> instruction_bank == $past(fetch_bank_staging))
    else $error("jump did not copy staging into instruction bank");

  chk_set_fetch_staging: assert property (
    take && is_set(instr_i, mfx_pkg::SUB_SET_FETCH) && !jump_i && !console_load_i && !intr_take_i
    |=> fetch_bank_staging == $past(instr_i[5:3]) && instruction_bank == $past(instruction_bank))
    else $error("set fetch bank misbehaved");

  chk_set_data_bank: assert property (
    take && is_set(instr_i, mfx_pkg::SUB_SET_DATA) && !intr_take_i
    |=> data_bank_select == $past(instr_i[5:3]))
    else $error("set data bank did not load N");

  chk_intr_save: assert property (
    intr_take_i |=> interrupt_bank_save == $past({instruction_bank, data_bank_select})
                    && instruction_bank == 3'h0)
    else $error("interrupt did not save fields");

  chk_restore_path: assert property (
    take && instr_i == mfx_pkg::OP_RESTORE && !intr_take_i && !console_load_i
    |=> fetch_bank_staging == $past(interrupt_bank_save[5:3])
        && data_bank_select == $past(interrupt_bank_save[2:0]))
    else $error("restore did not move saved banks");

  chk_iot_time: assert property (
    take |=> iot_busy_o [*8] ##[1:207] iot_done_o)
    else $error("transfer instruction took too long");

  chk_read_saved: assert property (
    take && instr_i == mfx_pkg::OP_READ_SAVED
    |=> work_reg_o == {$past(work_reg_i[11:6]), $past(interrupt_bank_save)})
    else $error("read saved banks wrong");

  chk_read_data_keep: assert property (
    take && instr_i == mfx_pkg::OP_READ_DATA
    |=> work_reg_o == {$past(work_reg_i[11:6]), $past(data_bank_select), $past(work_reg_i[2:0])})
    else $error("read data bank wrong");

  chk_operand_bank: assert property (
    cyc_kind_i == mfx_pkg::MFX_CYC_OPERAND && !intr_take_i |-> mem_bank_o == data_bank_select)
    else $error("operand cycle used wrong bank");

  chk_intr_bank_zero: assert property (
    intr_take_i |-> mem_bank_o == 3'h0)
    else $error("interrupt cycle not in bank 0");

  cov_cross_jump: cover property (take && is_set(instr_i, mfx_pkg::SUB_SET_FETCH) ##[1:300] jump_i);
  cov_intr_restore: cover property (intr_take_i ##[1:300] (take && instr_i == mfx_pkg::OP_RESTORE));
  cov_read_done: cover property (work_reg_load_o);

endmodule

`default_nettype wire

// >>> verif/mfx_seq_model.sv
// Instruction sequencer model that issues transfer instructions to the field control
`timescale 1ns/1ps
`default_nettype none

module mfx_seq_model
(
  // Clock
  input  wire logic        clk_i,
  // Transfer request
  output logic             iot_strobe_o,
  output logic      [11:0] instr_o,
  output logic      [11:0] work_reg_o,
  // Transfer answer
  input  wire logic        iot_done_i,
  input  wire logic [11:0] work_reg_i,
  input  wire logic        work_reg_load_i
);
  // Idle request lines
  initial
  begin
    iot_strobe_o = 1'b0;
    instr_o      = 12'h000;
    work_reg_o   = 12'h000;
  end

  // Place a plain word on the instruction lines for address decoding
  task automatic put(input logic [11:0] w);
    instr_o = w;
  endtask

  // One transfer: strobe for one cycle, then wait for done under a bound
  task automatic run(input logic [11:0] ins, input logic [11:0] wr, output logic [11:0] res,
                     output logic ld, output int unsigned cyc, output logic ok);
    begin
      ok           = 1'b0;
      res          = 12'h000;
      ld           = 1'b0;
      iot_strobe_o = 1'b1;
      instr_o      = ins;
      work_reg_o   = wr;
      @(negedge clk_i);
      // Released lines show the inverse so a stale value cannot pass
      iot_strobe_o = 1'b0;
      instr_o      = ~ins;
      work_reg_o   = ~wr;
      cyc          = 1;
      while (cyc < 1000 && ok == 1'b0)
      begin
        if (iot_done_i === 1'b1)
        begin
          ok  = 1'b1;
          res = work_reg_i;
          ld  = work_reg_load_i;
        end
        else
        begin
          @(negedge clk_i);
          cyc++;
        end
      end
      // Next request only once busy has dropped
      @(negedge clk_i);
    end
  endtask
endmodule

`default_nettype wire

// >>> verif/mfx_ctrl_tb_top.sv
// Self-checking testbench for the memory field extension control
`timescale 1ns/1ps
`default_nettype none

module mfx_ctrl_tb_top;
  // Shortened transfer time keeps the run brief
  localparam int unsigned NCYC = 10;

  logic              mclk_i;
  logic              reset_i;
  logic              strobe;
  logic [11:0]       instr;
  logic [11:0]       wr_in;
  logic              busy;
  logic              done;
  logic [11:0]       wr_out;
  logic              wr_ld;
  logic              jump;
  logic              intr;
  logic              cons_ld;
  logic [2:0]        cons_bank;
  logic              brk_ld;
  logic [2:0]        brk_bank;
  mfx_pkg::mfx_cyc_t cyc;
  logic [11:0]       pc;
  logic [2:0]        mem_bank;
  logic [11:0]       daddr;
  logic [11:0]       save_addr;
  logic [11:0]       next_addr;
  logic [4:0]        ib5;
  logic [4:0]        df5;
  logic [4:0]        st5;
  logic [9:0]        sf10;
  logic [2:0]        bf3;
  int unsigned       mismatches;
  int unsigned       n_checks;
  logic [11:0]       res;
  logic [11:0]       wr;
  logic              ld;
  logic [2:0]        a;
  logic [2:0]        b;
  logic [2:0]        c;

  // Clock of 20 ns period
  initial
  begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end

  mfx_ctrl #(.IOT_CYCLES(NCYC)) uut (.mclk_i(mclk_i), .reset_i(reset_i), .iot_strobe_i(strobe),
    .instr_i(instr), .work_reg_i(wr_in), .iot_busy_o(busy), .iot_done_o(done), .work_reg_o(wr_out),
    .work_reg_load_o(wr_ld), .jump_i(jump), .intr_take_i(intr), .console_load_i(cons_ld),
    .console_bank_i(cons_bank), .break_load_i(brk_ld), .break_bank_i(brk_bank), .cyc_kind_i(cyc),
    .pc_i(pc), .mem_bank_o(mem_bank), .direct_addr_o(daddr), .intr_save_addr_o(save_addr),
    .intr_next_addr_o(next_addr), .instruction_bank_o(ib5), .data_bank_select_o(df5),
    .fetch_bank_staging_o(st5), .interrupt_bank_save_o(sf10), .transfer_bank_select_o(bf3));

  mfx_seq_model seq (.clk_i(mclk_i), .iot_strobe_o(strobe), .instr_o(instr), .work_reg_o(wr_in),
    .iot_done_i(done), .work_reg_i(wr_out), .work_reg_load_i(wr_ld));

  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Event pulse of one cycle: 0 jump, 1 console, 2 break
  task automatic ev(input int k);
    begin
      jump    = (k == 0);
      cons_ld = (k == 1);
      brk_ld  = (k == 2);
      @(negedge mclk_i);
      jump    = 1'b0;
      cons_ld = 1'b0;
      brk_ld  = 1'b0;
    end
  endtask

  // Transfer with a timing check; a hang ends the run
  task automatic io_transfer_instr(input logic [11:0] ins, input logic [11:0] w);
    int unsigned n;
    logic        ok;
    begin
      seq.run(ins, w, res, ld, n, ok);
      if (ok !== 1'b1)
      begin
        mismatches++;
        report_and_stop();
      end
      chk(12'(n), 12'(NCYC));
      chk({11'h000, busy}, 12'h000);
    end
  endtask

  // Read result: work value with a bank in bits 6-8, optional low bank
  function automatic logic [11:0] ins_f(logic [11:0] w, logic [2:0] hi, logic [2:0] lo, logic use_lo);
    return {w[11:6], hi, (use_lo ? lo : w[2:0])};
  endfunction

  initial
  begin
    mismatches = 0;
    n_checks   = 0;
    reset_i    = 1'b1;
    jump       = 1'b0;
    intr       = 1'b0;
    cons_ld    = 1'b0;
    cons_bank  = 3'h0;
    brk_ld     = 1'b0;
    brk_bank   = 3'h0;
    cyc        = mfx_pkg::MFX_CYC_DIRECT;
    pc         = 12'h000;
    void'($urandom(71));
    repeat (16) @(negedge mclk_i);
    reset_i = 1'b0;
    chk({7'h00, ib5}, 12'h000);
    chk({7'h00, df5 | st5}, 12'h000);
    chk({2'h0, sf10}, 12'h000);
    chk({9'h000, bf3}, 12'h000);
    $display("test reset done");

    // Every bank number through both set ops and both field reads
    for (int i = 0; i < 8; i++)
    begin
      a  = 3'(i);
      wr = 12'($urandom);
      io_transfer_instr({6'h32, a, 3'h1}, wr);
      chk({7'h00, df5}, {7'h00, a, 2'b00});
      chk({11'h000, ld}, 12'h000);
      wr = 12'($urandom);
      io_transfer_instr(mfx_pkg::OP_READ_DATA, wr);
      chk(res, ins_f(wr, a, 3'h0, 1'b0));
      chk({11'h000, ld}, 12'h001);
      b = ib5[4:2];
      io_transfer_instr({6'h32, 3'(7 - i), 3'h2}, 12'($urandom));
      chk({7'h00, st5}, {7'h00, 3'(7 - i), 2'b00});
      chk({7'h00, ib5}, {7'h00, b, 2'b00});
      ev(0);
      chk({7'h00, ib5}, {7'h00, 3'(7 - i), 2'b00});
      wr = 12'($urandom);
      io_transfer_instr(mfx_pkg::OP_READ_FETCH, wr);
      chk(res, ins_f(wr, 3'(7 - i), 3'h0, 1'b0));
    end
    $display("test set_and_read done");

    // Console load, break bank and bank choice per cycle kind
    a         = 3'($urandom_range(1, 7));
    b         = 3'($urandom);
    c         = 3'($urandom);
    cons_bank = a;
    ev(1);
    chk({7'h00, ib5}, {7'h00, a, 2'b00});
    brk_bank = c;
    ev(2);
    chk({9'h000, bf3}, {9'h000, c});
    io_transfer_instr({6'h32, b, 3'h1}, 12'($urandom));
    cyc = mfx_pkg::MFX_CYC_DIRECT;
    #1 chk({9'h000, mem_bank}, {9'h000, a});
    cyc = mfx_pkg::MFX_CYC_POINTER;
    #1 chk({9'h000, mem_bank}, {9'h000, a});
    cyc = mfx_pkg::MFX_CYC_OPERAND;
    #1 chk({9'h000, mem_bank}, {9'h000, b});
    cyc = mfx_pkg::MFX_CYC_BREAK;
    #1 chk({9'h000, mem_bank}, {9'h000, c});
    for (int p = 0; p < 2; p++)
    begin
      wr    = 12'($urandom);
      wr[7] = p[0];
      pc    = 12'($urandom);
      seq.put(wr);
      #1 chk(daddr, (p == 1) ? {pc[11:7], wr[6:0]} : {5'h00, wr[6:0]});
    end
    @(negedge mclk_i);
    $display("test bank_select done");

    // Interrupt save, forced bank 0, read back and restore
    cyc  = mfx_pkg::MFX_CYC_DIRECT;
    intr = 1'b1;
    #1 chk({9'h000, mem_bank}, 12'h000);
    @(negedge mclk_i);
    intr = 1'b0;
    chk({2'h0, sf10}, {6'h00, a, b});
    chk({7'h00, ib5 | df5}, 12'h000);
    chk(save_addr, 12'h000);
    chk(next_addr, 12'h001);
    wr = 12'($urandom);
    io_transfer_instr(mfx_pkg::OP_READ_SAVED, wr);
    chk(res, ins_f(wr, a, b, 1'b1));
    io_transfer_instr(mfx_pkg::OP_RESTORE, 12'($urandom));
    chk({7'h00, st5}, {7'h00, a, 2'b00});
    chk({7'h00, df5}, {7'h00, b, 2'b00});
    chk({7'h00, ib5}, 12'h000);
    ev(0);
    chk({7'h00, ib5}, {7'h00, a, 2'b00});
    $display("test interrupt done");

    // Reset in mid-run must clear fields that now hold nonzero banks
    reset_i = 1'b1;
    @(negedge mclk_i);
    reset_i = 1'b0;
    chk({7'h00, ib5 | df5 | st5}, 12'h000);
    chk({2'h0, sf10}, 12'h000);
    chk({9'h000, bf3}, 12'h000);
    chk({11'h000, busy}, 12'h000);
    $display("test mid_reset done");
    report_and_stop();
  end
endmodule

`default_nettype wire
